/* art_timer.sv */
// Auto-reload 16-bit timer with split and capture modes, AXI4-Lite registers
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module art_timer (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rtcOscPin,
  input  wire logic        extOscPin,
  output var  logic        timerIrq
);

  function automatic art_pkg::art_reg_t decodeAddr(input logic [7:0] addr);
    if (addr == art_pkg::OFF_CTRL) begin
      return art_pkg::REG_CTRL;
    end else if (addr == art_pkg::OFF_RLO) begin
      return art_pkg::REG_RLO;
    end else if (addr == art_pkg::OFF_RHI) begin
      return art_pkg::REG_RHI;
    end else if (addr == art_pkg::OFF_CLO) begin
      return art_pkg::REG_CLO;
    end else if (addr == art_pkg::OFF_CHI) begin
      return art_pkg::REG_CHI;
    end else if (addr == art_pkg::OFF_CKC) begin
      return art_pkg::REG_CKC;
    end else if (addr == art_pkg::OFF_IEN) begin
      return art_pkg::REG_IEN;
    end else begin
      return art_pkg::REG_NONE;
    end
  endfunction

  // Per-half tick select from own select bit and shared external select
  function automatic logic pickTick(input logic sysSel, input logic [1:0] extSel,
                                    input logic slowTick, input logic rtcTick, input logic extTick);
    if (sysSel) begin
      return 1'h1;
    end else if (extSel == art_pkg::XSEL_SLOW) begin
      return slowTick;
    end else if (extSel == art_pkg::XSEL_RTC) begin
      return rtcTick;
    end else if (extSel == art_pkg::XSEL_EXT) begin
      return extTick;
    end else begin
      return 1'h0;
    end
  endfunction

  // Bus state
  logic              awHeld_ff;
  logic              wHeld_ff;
  logic [7:0]        awAddr_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              awready_ff;
  logic              wready_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              nxt_awHeld;
  logic              nxt_wHeld;
  logic [7:0]        nxt_awAddr;
  logic [31:0]       nxt_wData;
  logic [3:0]        nxt_wStrb;
  logic              nxt_awready;
  logic              nxt_wready;
  logic              nxt_bvalid;
  logic [1:0]        nxt_bresp;
  logic              nxt_arready;
  logic              nxt_rvalid;
  logic [31:0]       nxt_rdata;
  logic [1:0]        nxt_rresp;
  logic              wrEn;
  art_pkg::art_reg_t wrReg;
  art_pkg::art_reg_t rdReg;

  // Timer state
  art_pkg::art_ctrl_t ctrl_ff;
  art_pkg::art_ckc_t  ckc_ff;
  logic               ien_ff;
  logic [7:0]         reloadLo_ff;
  logic [7:0]         reloadHi_ff;
  logic [7:0]         countLo_ff;
  logic [7:0]         countHi_ff;
  logic               irq_ff;
  logic [3:0]         slowCnt_ff;
  logic [2:0]         extCnt_ff;
  art_pkg::art_ctrl_t nxt_ctrl;
  art_pkg::art_ckc_t  nxt_ckc;
  logic               nxt_ien;
  logic [7:0]         nxt_reloadLo;
  logic [7:0]         nxt_reloadHi;
  logic [7:0]         nxt_countLo;
  logic [7:0]         nxt_countHi;
  logic               nxt_irq;
  logic [3:0]         nxt_slowCnt;
  logic [2:0]         nxt_extCnt;
  logic               setHi;
  logic               setLo;
  logic [15:0]        count16;
  logic [1:0]         pinIn;
  logic [1:0]         pinRise;
  logic               slowTick;
  logic               rtcTick;
  logic               extTick;
  logic               tickLo;
  logic               tickHi;
  logic               capEvent;

  // Slow pins into the clock domain
  assign pinIn = {extOscPin, rtcOscPin};
  for (genvar g = 0; g < 2; g++) begin : gSync
    art_sync_edge uSync (
      .mclk      (mclk),
      .reset     (reset),
      .pinAsync  (pinIn[g]),
      .risePulse (pinRise[g])
    );
  end

  // Tick sources
  always_comb begin
    slowTick    = (slowCnt_ff == art_pkg::SLOW_LAST);
    nxt_slowCnt = slowTick ? 4'h0 : slowCnt_ff + 4'h1;
    rtcTick     = pinRise[0];
    extTick     = pinRise[1] && (extCnt_ff == art_pkg::EXT_LAST);
    nxt_extCnt  = pinRise[1] ? extCnt_ff + 3'h1 : extCnt_ff;
    tickLo      = pickTick(ckc_ff.loSysSel, ctrl_ff.extSel, slowTick, rtcTick, extTick);
    tickHi      = pickTick(ckc_ff.hiSysSel, ctrl_ff.extSel, slowTick, rtcTick, extTick);
    capEvent    = ctrl_ff.capEn && (ctrl_ff.extSel[1] ? extTick : rtcTick);
  end

  // Bus handshakes
  always_comb begin
    nxt_awHeld  = awHeld_ff;
    nxt_wHeld   = wHeld_ff;
    nxt_awAddr  = awAddr_ff;
    nxt_wData   = wData_ff;
    nxt_wStrb   = wStrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    wrReg       = decodeAddr(awAddr_ff);
    rdReg       = decodeAddr(s_axi_araddr);
    wrEn        = awHeld_ff && wHeld_ff && !bvalid_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awHeld = 1'h1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wHeld = 1'h1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (wrEn) begin
      nxt_awHeld = 1'h0;
      nxt_wHeld  = 1'h0;
      nxt_bvalid = 1'h1;
      nxt_bresp  = (wrReg == art_pkg::REG_NONE) ? art_pkg::RESP_SLVERR : art_pkg::RESP_OKAY;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'h0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'h1;
      nxt_rresp  = art_pkg::RESP_OKAY;
      if (rdReg == art_pkg::REG_CTRL) begin
        nxt_rdata = {24'h000000, ctrl_ff};
      end else if (rdReg == art_pkg::REG_RLO) begin
        nxt_rdata = {24'h000000, reloadLo_ff};
      end else if (rdReg == art_pkg::REG_RHI) begin
        nxt_rdata = {24'h000000, reloadHi_ff};
      end else if (rdReg == art_pkg::REG_CLO) begin
        nxt_rdata = {24'h000000, countLo_ff};
      end else if (rdReg == art_pkg::REG_CHI) begin
        nxt_rdata = {24'h000000, countHi_ff};
      end else if (rdReg == art_pkg::REG_CKC) begin
        nxt_rdata = {30'h00000000, ckc_ff};
      end else if (rdReg == art_pkg::REG_IEN) begin
        nxt_rdata = {31'h00000000, ien_ff};
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = art_pkg::RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'h0;
    end
    nxt_awready = !nxt_awHeld && !nxt_bvalid;
    nxt_wready  = !nxt_wHeld && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld_ff  <= 1'h0;
      wHeld_ff   <= 1'h0;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h00000000;
      wStrb_ff   <= 4'h0;
      awready_ff <= 1'h0;
      wready_ff  <= 1'h0;
      bvalid_ff  <= 1'h0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'h0;
      rvalid_ff  <= 1'h0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= 2'h0;
    end else begin
      awHeld_ff  <= nxt_awHeld;
      wHeld_ff   <= nxt_wHeld;
      awAddr_ff  <= nxt_awAddr;
      wData_ff   <= nxt_wData;
      wStrb_ff   <= nxt_wStrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // Counter, reload, flags and interrupt
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_ckc      = ckc_ff;
    nxt_ien      = ien_ff;
    nxt_reloadLo = reloadLo_ff;
    nxt_reloadHi = reloadHi_ff;
    nxt_countLo  = countLo_ff;
    nxt_countHi  = countHi_ff;
    setHi        = 1'h0;
    setLo        = 1'h0;
    count16      = {countHi_ff, countLo_ff};
    if (!ctrl_ff.split) begin
      if (ctrl_ff.run && tickLo) begin
        setLo = (countLo_ff == 8'hff);
        if (count16 == 16'hffff) begin
          if (ctrl_ff.capEn) begin
            {nxt_countHi, nxt_countLo} = 16'h0000;
          end else begin
            {nxt_countHi, nxt_countLo} = {reloadHi_ff, reloadLo_ff};
            setHi = 1'h1;
          end
        end else begin
          {nxt_countHi, nxt_countLo} = count16 + 16'h0001;
        end
      end
    end else begin
      if (tickLo) begin
        if (countLo_ff == 8'hff) begin
          nxt_countLo = reloadLo_ff;
          setLo = 1'h1;
        end else begin
          nxt_countLo = countLo_ff + 8'h01;
        end
      end
      if (ctrl_ff.run && tickHi) begin
        if (countHi_ff == 8'hff) begin
          nxt_countHi = reloadHi_ff;
          setHi = 1'h1;
        end else begin
          nxt_countHi = countHi_ff + 8'h01;
        end
      end
    end
    if (capEvent) begin
      nxt_reloadHi = countHi_ff;
      nxt_reloadLo = countLo_ff;
      setHi = 1'h1;
    end
    if (wrEn && wStrb_ff[0]) begin
      if (wrReg == art_pkg::REG_CTRL) begin
        nxt_ctrl = art_pkg::art_ctrl_t'(wData_ff[7:0]);
      end else if (wrReg == art_pkg::REG_RLO) begin
        nxt_reloadLo = wData_ff[7:0];
      end else if (wrReg == art_pkg::REG_RHI) begin
        nxt_reloadHi = wData_ff[7:0];
      end else if (wrReg == art_pkg::REG_CLO) begin
        nxt_countLo = wData_ff[7:0];
      end else if (wrReg == art_pkg::REG_CHI) begin
        nxt_countHi = wData_ff[7:0];
      end else if (wrReg == art_pkg::REG_CKC) begin
        nxt_ckc = art_pkg::art_ckc_t'(wData_ff[1:0]);
      end else if (wrReg == art_pkg::REG_IEN) begin
        nxt_ien = wData_ff[0];
      end
    end
    // Hardware set wins over a software clear
    nxt_ctrl.hiFlag = nxt_ctrl.hiFlag | setHi;
    nxt_ctrl.loFlag = nxt_ctrl.loFlag | setLo;
    nxt_irq = nxt_ien && (nxt_ctrl.hiFlag || (nxt_ctrl.loIrqEn && nxt_ctrl.loFlag));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff     <= art_pkg::art_ctrl_t'(art_pkg::CTRL_RST);
      ckc_ff      <= art_pkg::art_ckc_t'(art_pkg::CKC_RST);
      ien_ff      <= art_pkg::IEN_RST;
      reloadLo_ff <= art_pkg::BYTE_RST;
      reloadHi_ff <= art_pkg::BYTE_RST;
      countLo_ff  <= art_pkg::BYTE_RST;
      countHi_ff  <= art_pkg::BYTE_RST;
      irq_ff      <= 1'h0;
      slowCnt_ff  <= 4'h0;
      extCnt_ff   <= 3'h0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      ckc_ff      <= nxt_ckc;
      ien_ff      <= nxt_ien;
      reloadLo_ff <= nxt_reloadLo;
      reloadHi_ff <= nxt_reloadHi;
      countLo_ff  <= nxt_countLo;
      countHi_ff  <= nxt_countHi;
      irq_ff      <= nxt_irq;
      slowCnt_ff  <= nxt_slowCnt;
      extCnt_ff   <= nxt_extCnt;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign timerIrq      = irq_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  chk_wrap_reload: assert property (
    !ctrl_ff.split && !ctrl_ff.capEn && ctrl_ff.run && tickLo && count16 == 16'hffff && !wrEn
    |=> {countHi_ff, countLo_ff} == $past({reloadHi_ff, reloadLo_ff}) && ctrl_ff.hiFlag)
    else $error("16-bit wrap did not reload or flag");

  chk_run_hold: assert property (
    !ctrl_ff.split && !ctrl_ff.run && !wrEn |=> $stable(count16))
    else $error("16-bit counter moved while stopped");

  chk_low_reload: assert property (
    ctrl_ff.split && tickLo && countLo_ff == 8'hff && !wrEn
    |=> countLo_ff == $past(reloadLo_ff) && ctrl_ff.loFlag)
    else $error("low half did not reload on wrap");

  chk_low_free: assert property (
    ctrl_ff.split && !ctrl_ff.run && tickLo && countLo_ff != 8'hff && !wrEn
    |=> countLo_ff == $past(countLo_ff) + 8'h01 && $stable(countHi_ff))
    else $error("split halves not gated as expected");

  chk_high_wrap: assert property (
    ctrl_ff.split && ctrl_ff.run && tickHi && countHi_ff == 8'hff && !wrEn
    |=> countHi_ff == $past(reloadHi_ff) && ctrl_ff.hiFlag)
    else $error("high half wrap did not reload or flag");

  chk_flag_sticky: assert property (
    ctrl_ff.hiFlag && ctrl_ff.loFlag && !(wrEn && wrReg == art_pkg::REG_CTRL)
    |=> ctrl_ff.hiFlag && ctrl_ff.loFlag)
    else $error("overflow flag cleared without a write");

  chk_capture_copy: assert property (
    capEvent && !wrEn |=> {reloadHi_ff, reloadLo_ff} == $past(count16) && ctrl_ff.hiFlag)
    else $error("capture did not copy count");

  chk_irq_follow: assert property (
    ien_ff && ctrl_ff.hiFlag && !wrEn |=> timerIrq)
    else $error("interrupt missing for high overflow");

  chk_low_irq: assert property (
    !ien_ff && !wrEn |=> !timerIrq)
    else $error("interrupt raised while disabled");

  chk_slow_div: assert property (
    slowTick |=> !slowTick [*8])
    else $error("system clock divide by twelve too fast");

  chk_slow_period: assert property (
    slowTick |-> ##12 slowTick)
    else $error("system clock divide by twelve too slow");

  chk_low_irq_on: assert property (
    ien_ff && ctrl_ff.loIrqEn && ctrl_ff.loFlag && !wrEn |=> timerIrq)
    else $error("interrupt missing for low overflow");

endmodule
`default_nettype wire

/* art_pkg.sv */
// Shared constants and types for the auto-reload timer with capture
package art_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BYTE_W   = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_RLO   = 8'h04;
  localparam logic [7:0] OFF_RHI   = 8'h08;
  localparam logic [7:0] OFF_CLO   = 8'h0c;
  localparam logic [7:0] OFF_CHI   = 8'h10;
  localparam logic [7:0] OFF_CKC   = 8'h14;
  localparam logic [7:0] OFF_IEN   = 8'h18;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [1:0] CKC_RST   = 2'h0;
  localparam logic       IEN_RST   = 1'h0;

  // Clock source dividers
  localparam int unsigned DIV_SLOW  = 12;
  localparam int unsigned DIV_EXT   = 8;
  localparam logic [3:0]  SLOW_LAST = 4'(DIV_SLOW - 1);
  localparam logic [2:0]  EXT_LAST  = 3'(DIV_EXT - 1);

  // External clock select encodings
  localparam logic [1:0] XSEL_SLOW = 2'h0;
  localparam logic [1:0] XSEL_RTC  = 2'h1;
  localparam logic [1:0] XSEL_RSVD = 2'h2;
  localparam logic [1:0] XSEL_EXT  = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_RLO,
    REG_RHI,
    REG_CLO,
    REG_CHI,
    REG_CKC,
    REG_IEN,
    REG_NONE
  } art_reg_t;

  typedef struct packed {
    logic       hiFlag;
    logic       loFlag;
    logic       loIrqEn;
    logic       capEn;
    logic       split;
    logic       run;
    logic [1:0] extSel;
  } art_ctrl_t;

  typedef struct packed {
    logic hiSysSel;
    logic loSysSel;
  } art_ckc_t;
endpackage

/* art_sync_edge.sv */
// Two-flop synchroniser with rising edge pulse
`timescale 1ns/1ns
`default_nettype none
module art_sync_edge (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pinAsync,
  output var  logic risePulse
);
  logic syncA_ff;
  logic syncB_ff;
  logic prev_ff;
  logic rise_ff;
  logic nxt_rise;

  always_comb begin
    nxt_rise = syncB_ff & ~prev_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      syncA_ff <= 1'h0;
      syncB_ff <= 1'h0;
      prev_ff  <= 1'h0;
      rise_ff  <= 1'h0;
    end else begin
      syncA_ff <= pinAsync;
      syncB_ff <= syncA_ff;
      prev_ff  <= syncB_ff;
      rise_ff  <= nxt_rise;
    end
  end

  assign risePulse = rise_ff;
endmodule
`default_nettype wire

/* test_auto_reload_timer_with_capture.sv */
// Self-checking bench for the auto-reload timer with capture
`timescale 1ns/1ns
`default_nettype none
module test_auto_reload_timer_with_capture;
  localparam logic [7:0] CTL = art_pkg::OFF_CTRL;
  localparam logic [7:0] RLO = art_pkg::OFF_RLO;
  localparam logic [7:0] RHI = art_pkg::OFF_RHI;
  localparam logic [7:0] CLO = art_pkg::OFF_CLO;
  localparam logic [7:0] CHI = art_pkg::OFF_CHI;
  localparam logic [7:0] CKC = art_pkg::OFF_CKC;
  localparam logic [7:0] IEN = art_pkg::OFF_IEN;
  logic        mclk;
  logic        reset;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        rtcOscPin;
  logic        extOscPin;
  logic        timerIrq;
  logic [1:0]  lastResp;
  int          mismatches;
  int          nCompared;
  int          cyc;
  int          riseAt;

  art_timer dut_u (.mclk(mclk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rtcOscPin(rtcOscPin), .extOscPin(extOscPin), .timerIrq(timerIrq));

  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge mclk);
    check({31'h0, timerIrq}, {31'h0, e});
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    logic b;
    b = 1'b0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b) begin
      @(negedge mclk);
      aw = s_axi_awready & s_axi_awvalid;
      w = s_axi_wready & s_axi_wvalid;
      b = s_axi_bvalid;
      lastResp = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar;
    logic rv;
    rv = 1'b0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!rv) begin
      @(negedge mclk);
      ar = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      lastResp = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Oscillator pin rises, eight cycles apart
  task automatic pulse(input logic ext, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (ext) extOscPin <= 1'b1;
      else rtcOscPin <= 1'b1;
      riseAt = cyc;
      wcyc(4);
      extOscPin <= 1'b0;
      rtcOscPin <= 1'b0;
      wcyc(3);
    end
  endtask

  task automatic t_reset;
    logic [7:0]  offs [7];
    logic [31:0] v;
    offs = '{CTL, RLO, RHI, CLO, CHI, CKC, IEN};
    for (int i = 0; i < 7; i++) begin
      rd(offs[i], v);
      check(v, 32'h00000000);
      check({30'h0, lastResp}, {30'h0, art_pkg::RESP_OKAY});
    end
    rd(8'h1c, v);
    check({30'h0, lastResp}, {30'h0, art_pkg::RESP_SLVERR});
    wr(8'h1c, 8'h5a);
    check({30'h0, lastResp}, {30'h0, art_pkg::RESP_SLVERR});
    chk_irq(1'b0);
    $display("done reset values");
  endtask

  task automatic t_wide;
    logic [31:0] v;
    wr(CKC, 8'h01);
    wr(IEN, 8'h01);
    wr(RLO, 8'h00);
    wr(RHI, 8'h55);
    wr(CLO, 8'hf0);
    wr(CHI, 8'hff);
    wr(CTL, 8'h04);
    wcyc(40);
    rd(CTL, v);
    check(v, 32'hc4);
    rd(CHI, v);
    check(v, 32'h55);
    chk_irq(1'b1);
    wcyc(100);
    rd(CTL, v);
    check(v, 32'hc4);
    wr(CTL, 8'h00);
    wcyc(2);
    chk_irq(1'b0);
    wr(CLO, 8'hf8);
    wr(CHI, 8'h00);
    wr(CTL, 8'h24);
    wcyc(30);
    rd(CTL, v);
    check(v, 32'h64);
    chk_irq(1'b1);
    wr(CTL, 8'h44);
    wcyc(2);
    chk_irq(1'b0);
    wr(CTL, 8'h64);
    wr(IEN, 8'h00);
    wcyc(2);
    chk_irq(1'b0);
    wr(IEN, 8'h01);
    wr(CTL, 8'h00);
    $display("done sixteen bit mode");
  endtask

  task automatic t_split;
    logic [31:0] v;
    wr(CKC, 8'h03);
    wr(RLO, 8'h80);
    wr(RHI, 8'h40);
    wr(CLO, 8'hf0);
    wr(CHI, 8'hf0);
    wr(CTL, 8'h08);
    wcyc(40);
    rd(CTL, v);
    check(v, 32'h48);
    rd(CHI, v);
    check(v, 32'hf0);
    rd(CLO, v);
    check({30'h0, v[7:6]}, 32'h2);
    chk_irq(1'b0);
    wr(CTL, 8'h6c);
    wcyc(2);
    chk_irq(1'b1);
    wcyc(30);
    rd(CTL, v);
    check(v, 32'hec);
    rd(CHI, v);
    check({30'h0, v[7:6]}, 32'h1);
    wr(CTL, 8'h00);
    wr(CKC, 8'h00);
    wr(CTL, 8'h08);
    wr(CLO, 8'h00);
    wcyc(240);
    rd(CLO, v);
    check({31'h0, v >= 19 && v <= 22}, 32'h1);
    wr(CTL, 8'h09);
    wr(CLO, 8'h00);
    pulse(1'b0, 3);
    rd(CLO, v);
    check(v, 32'h3);
    wr(CTL, 8'h0a);
    wr(CLO, 8'h00);
    pulse(1'b0, 3);
    pulse(1'b1, 8);
    rd(CLO, v);
    check(v, 32'h0);
    wr(CTL, 8'h0f);
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    pulse(1'b1, 16);
    rd(CLO, v);
    check(v, 32'h2);
    rd(CHI, v);
    check(v, 32'h2);
    wr(CTL, 8'h00);
    $display("done split mode and clock sources");
  endtask

  task automatic capture(output logic [15:0] c);
    logic [31:0] v;
    rd(RLO, v);
    c[7:0] = v[7:0];
    rd(RHI, v);
    c[15:8] = v[7:0];
  endtask

  task automatic t_capture;
    logic [31:0] v;
    logic [15:0] c1;
    logic [15:0] c2;
    int          t1;
    int          k;
    wr(CKC, 8'h01);
    wr(CTL, 8'h14);
    pulse(1'b0, 1);
    t1 = riseAt;
    rd(CTL, v);
    check(v, 32'h94);
    chk_irq(1'b1);
    capture(c1);
    wr(CTL, 8'h14);
    wcyc(50);
    pulse(1'b0, 1);
    capture(c2);
    check({16'h0, c2 - c1}, {16'h0, 16'(riseAt - t1)});
    wr(CTL, 8'h17);
    wr(CLO, 8'h00);
    k = 0;
    v = 32'h0;
    while (!v[7] && k < 9) begin
      pulse(1'b1, 1);
      rd(CTL, v);
      k++;
    end
    t1 = riseAt;
    capture(c1);
    wr(CTL, 8'h17);
    pulse(1'b1, 7);
    rd(CTL, v);
    check(v, 32'h17);
    pulse(1'b1, 1);
    rd(CTL, v);
    check(v, 32'h97);
    capture(c2);
    check({16'h0, c2 - c1}, {16'h0, 16'(riseAt - t1)});
    wr(CTL, 8'h00);
    $display("done capture mode");
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    cyc = 0;
    riseAt = 0;
    mismatches = 0;
    nCompared = 0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    rtcOscPin = 1'b0;
    extOscPin = 1'b0;
    wcyc(6);
    reset <= 1'b0;
    wcyc(1);
    t_reset();
    t_wide();
    t_split();
    t_capture();
    stop_test();
  end

  initial begin
    wcyc(20000);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
